// ==== core/iocae_pkg.sv ====
// constants, types and register map of the channel alarm evaluator
package iocae_pkg;
  typedef logic signed [31:0] iocae_val_t;

  localparam int IDX_W = 5;
  localparam int ADDR_LSB = 2;
  localparam logic [IDX_W-1:0] IDX_CTRL = 5'h00;
  localparam logic [IDX_W-1:0] IDX_ENABLE = 5'h01;
  localparam logic [IDX_W-1:0] IDX_LOW_LOW_THRESHOLD = 5'h02;
  localparam logic [IDX_W-1:0] IDX_LO = 5'h03;
  localparam logic [IDX_W-1:0] IDX_HI = 5'h04;
  localparam logic [IDX_W-1:0] IDX_HIGH_HIGH_THRESHOLD = 5'h05;
  localparam logic [IDX_W-1:0] IDX_LRV = 5'h06;
  localparam logic [IDX_W-1:0] IDX_GAIN = 5'h07;
  localparam logic [IDX_W-1:0] IDX_CUTOFF = 5'h08;
  localparam logic [IDX_W-1:0] IDX_OVLD = 5'h09;
  localparam logic [IDX_W-1:0] IDX_LSCALE = 5'h0A;
  localparam logic [IDX_W-1:0] IDX_HSCALE = 5'h0B;
  localparam logic [IDX_W-1:0] IDX_LFREQ = 5'h0C;
  localparam logic [IDX_W-1:0] IDX_HFREQ = 5'h0D;
  localparam logic [IDX_W-1:0] IDX_QMIN = 5'h0E;
  localparam logic [IDX_W-1:0] IDX_QMAX = 5'h0F;
  localparam logic [IDX_W-1:0] IDX_QCUT = 5'h10;
  localparam logic [IDX_W-1:0] IDX_OVF = 5'h11;
  localparam logic [IDX_W-1:0] IDX_DEV = 5'h12;
  localparam logic [IDX_W-1:0] IDX_MAXFREQ = 5'h13;
  localparam logic [IDX_W-1:0] IDX_TMO = 5'h14;
  localparam logic [IDX_W-1:0] IDX_STATUS = 5'h15;
  localparam logic [IDX_W-1:0] IDX_VALUE = 5'h16;
  localparam int NUM_CFG = 21;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PEER_LSB = 3;
  localparam int EN_UNDER = 0;
  localparam int EN_OVER = 1;
  localparam int EN_LIM_LSB = 2;

  // current figures in microamps
  localparam iocae_val_t CUR_UNDER_SET_UA = 32'sh00000DAC;
  localparam iocae_val_t CUR_UNDER_CLR_UA = 32'sh00000FA0;
  localparam iocae_val_t CUR_OVER_SET_UA = 32'sh00005014;
  localparam iocae_val_t CUR_OVER_CLR_UA = 32'sh00004E20;
  localparam iocae_val_t CUR_ZERO_UA = 32'sh00000FA0;

  localparam int GAIN_SHIFT = 16;
  localparam int OVF_FRAC = 8;
  localparam int CRIT_HALF_SHIFT = 1;
  localparam logic [3:0] PULSE_WINDOW_S = 4'hA;
  localparam int CLK_HZ = 200000000;
  localparam int TICK_MS = 1;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000 * TICK_MS;

  typedef enum logic [2:0] {
    MODE_LOOP,
    MODE_DP,
    MODE_SCALE,
    MODE_FREQ,
    MODE_PULSE
  } iocae_mode_e;

  typedef struct packed {
    logic low_low_threshold;
    logic lo;
    logic hi;
    logic high_high_threshold;
  } iocae_lim_s;

  typedef struct packed {
    logic timeout;
    logic pulse_out_ovl;
    logic critical;
    logic overload;
    logic discrepancy;
    logic cutoff;
    logic over;
    logic under;
    iocae_lim_s lim;
  } iocae_alarm_s;

  typedef struct packed {
    logic flow_inhibit;
    logic totalize_stop;
    logic fault_totals;
  } iocae_proc_s;
endpackage

// ==== core/iocae_limit_cmp.sv ====
// four threshold comparator with per-limit enables
`timescale 1ns/1ps
module iocae_limit_cmp
  import iocae_pkg::*;
(
  input wire iocae_val_t value,
  input wire iocae_val_t low_low_threshold_th,
  input wire iocae_val_t lo_th,
  input wire iocae_val_t hi_th,
  input wire iocae_val_t high_high_threshold_th,
  input wire logic [3:0] enable,
  output iocae_lim_s lim
);
  always_comb begin
    lim.low_low_threshold = (value < low_low_threshold_th) && enable[0];
    lim.lo = (value < lo_th) && enable[1];
    lim.hi = (value > hi_th) && enable[2];
    lim.high_high_threshold = (value > high_high_threshold_th) && enable[3];
  end
endmodule

// ==== core/iocae_top.sv ====
// channel alarm evaluator with ahb-lite register slave
`timescale 1ns/1ps
//
// Contract
// - loop under-range sets below 3.5 mA, clears only above 4 mA
// - between 3.5 and 4 mA a fixed 4 mA is converted
// - loop over-range sets above 20.5 mA, clears only below 20 mA
// - between 20 and 20.5 mA the measured current is converted unclamped
// - value compared with four thresholds, low_low_threshold/lo below, hi/high_high_threshold above
// - dp below cut-off and not under-range raises cut-off alarm and passes zero
// - dp peers deviating beyond the limit raise discrepancy
// - dp below lower range value flags under-range, inhibits flow
// - dp above overload flags over-range, substitutes overload, fault totals
// - each range and limit alarm has an enable; disabled alarms suppressed
// - scale and frequency channels compare against low and high bounds
// - flowrate below cut-off raises cut-off alarm, stops totalizing
// - flowrate between cut-off and minimum flags under-range, fault totals
// - flowrate above maximum flags over-range, fault totals; else normal
// - flowrate above factor times maximum raises meter overload
// - above 1.5 times that, critical overload and clamp to 1.5 times the product
// - flowrate computed in every region
// - flowrate compared with the four limits
// - pending pulses above ten seconds at maximum frequency flag overload
// - serial value not rewritten within timeout raises timeout alarm
// - alarms are unlatched and clear when the cause goes
module iocae_top
  import iocae_pkg::*;
#(
  parameter int CYCLES_PER_TICK = CYCLES_PER_MS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sample_valid,
  input wire iocae_val_t sample_value,
  input wire iocae_val_t peer_a_value,
  input wire iocae_val_t peer_b_value,
  input wire logic [31:0] pulse_pending,
  input wire logic serial_write,
  output iocae_alarm_s alarms,
  output iocae_val_t calc_value,
  output iocae_proc_s proc
);
  logic rst_meta_reg;
  logic rst_sync_reg;
  iocae_val_t cfg_reg [NUM_CFG];
  logic wr_pend_reg;
  logic [IDX_W-1:0] wr_idx_reg;
  logic [IDX_W-1:0] rd_idx;
  logic [31:0] rdata_next;
  logic hyst_under_reg;
  logic hyst_under_next;
  logic hyst_over_reg;
  logic hyst_over_next;
  iocae_alarm_s eval_reg;
  iocae_alarm_s eval_next;
  iocae_val_t value_reg;
  iocae_val_t value_next;
  iocae_proc_s proc_reg;
  iocae_proc_s proc_next;
  iocae_lim_s lim;
  logic pulse_ovl_reg;
  logic timeout_reg;
  logic [17:0] tick_cnt_reg;
  logic [31:0] since_ms_reg;
  iocae_mode_e mode;
  iocae_val_t cur_conv;
  iocae_val_t eng;
  iocae_val_t meas;
  iocae_val_t tmq;
  iocae_val_t crit;
  logic signed [63:0] prod;
  logic signed [63:0] qprod;
  logic [1:0] peers;
  logic [35:0] pulse_cap;
  logic dev_a;
  logic dev_b;
  logic addr_ok;

  function automatic logic [32:0] absdiff(input iocae_val_t a, input iocae_val_t b);
    logic signed [32:0] d;
    d = $signed({a[31], a}) - $signed({b[31], b});
    return d[32] ? 33'(-d) : 33'(d);
  endfunction

  function automatic logic signed [63:0] mul_s(input iocae_val_t a, input iocae_val_t b);
    return $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // bus slave, zero wait states
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_idx = haddr[ADDR_LSB +: IDX_W];
  assign addr_ok = (haddr[31:ADDR_LSB+IDX_W] == '0) && (hsize == 3'h2);

  always_comb begin
    rdata_next = 32'h00000000;
    if (rd_idx < IDX_W'(NUM_CFG)) begin
      rdata_next = cfg_reg[rd_idx];
    end else if (rd_idx == IDX_STATUS) begin
      rdata_next = 32'(alarms);
    end else if (rd_idx == IDX_VALUE) begin
      rdata_next = value_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= '0;
      hrdata <= 32'h00000000;
    end else if (hready) begin
      wr_pend_reg <= hsel && htrans[1] && hwrite && addr_ok;
      wr_idx_reg <= rd_idx;
      if (hsel && htrans[1] && !hwrite && addr_ok) begin
        hrdata <= rdata_next;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg_reg[i] <= 32'h00000000;
      end
    end else if (wr_pend_reg && wr_idx_reg < IDX_W'(NUM_CFG)) begin
      cfg_reg[wr_idx_reg] <= hwdata;
    end
  end

  // current-loop conversion and hysteresis
  always_comb begin
    mode = iocae_mode_e'(cfg_reg[IDX_CTRL][CTRL_MODE_LSB +: 3]);
    peers = cfg_reg[IDX_CTRL][CTRL_PEER_LSB +: 2];
    cur_conv = (sample_value < CUR_ZERO_UA) ? CUR_ZERO_UA : sample_value;
    prod = mul_s(cur_conv - CUR_ZERO_UA, cfg_reg[IDX_GAIN]);
    eng = cfg_reg[IDX_LRV] + iocae_val_t'(prod >>> GAIN_SHIFT);
    hyst_under_next = hyst_under_reg ? !(sample_value > CUR_UNDER_CLR_UA)
                                     : (sample_value < CUR_UNDER_SET_UA);
    hyst_over_next = hyst_over_reg ? !(sample_value < CUR_OVER_CLR_UA)
                                   : (sample_value > CUR_OVER_SET_UA);
    meas = (mode == MODE_LOOP || mode == MODE_DP) ? eng : sample_value;
    qprod = mul_s(cfg_reg[IDX_QMAX], cfg_reg[IDX_OVF]);
    tmq = iocae_val_t'(qprod >>> OVF_FRAC);
    crit = tmq + (tmq >>> CRIT_HALF_SHIFT);
    dev_a = (peers != 2'h0) && (absdiff(meas, peer_a_value) > {1'b0, cfg_reg[IDX_DEV]});
    dev_b = (peers >= 2'h2) && (absdiff(meas, peer_b_value) > {1'b0, cfg_reg[IDX_DEV]});
  end

  iocae_limit_cmp u_lim (
    .value(meas),
    .low_low_threshold_th(cfg_reg[IDX_LOW_LOW_THRESHOLD]),
    .lo_th(cfg_reg[IDX_LO]),
    .hi_th(cfg_reg[IDX_HI]),
    .high_high_threshold_th(cfg_reg[IDX_HIGH_HIGH_THRESHOLD]),
    .enable(cfg_reg[IDX_ENABLE][EN_LIM_LSB +: 4]),
    .lim(lim)
  );

  // region evaluation per channel kind
  always_comb begin
    eval_next = '0;
    proc_next = '0;
    value_next = meas;
    eval_next.lim = lim;
    unique case (mode)
      MODE_LOOP: begin
        eval_next.under = hyst_under_next;
        eval_next.over = hyst_over_next;
      end
      MODE_DP: begin
        eval_next.under = hyst_under_next || (sample_value < CUR_ZERO_UA);
        proc_next.flow_inhibit = eval_next.under;
        eval_next.discrepancy = dev_a || dev_b;
        if (eng > cfg_reg[IDX_OVLD]) begin
          eval_next.over = 1'b1;
          value_next = cfg_reg[IDX_OVLD];
          proc_next.fault_totals = 1'b1;
        end else begin
          eval_next.over = hyst_over_next;
        end
        if (!eval_next.under && eng < cfg_reg[IDX_CUTOFF]) begin
          eval_next.cutoff = 1'b1;
          value_next = '0;
        end
      end
      MODE_SCALE: begin
        eval_next.under = sample_value < cfg_reg[IDX_LSCALE];
        eval_next.over = sample_value > cfg_reg[IDX_HSCALE];
      end
      MODE_FREQ: begin
        eval_next.under = sample_value < cfg_reg[IDX_LFREQ];
        eval_next.over = sample_value > cfg_reg[IDX_HFREQ];
      end
      MODE_PULSE: begin
        // flowrate passes through in every region except critical overload, which clamps to crit
        if (sample_value < cfg_reg[IDX_QCUT]) begin
          eval_next.cutoff = 1'b1;
          proc_next.totalize_stop = 1'b1;
        end else if (sample_value < cfg_reg[IDX_QMIN]) begin
          eval_next.under = 1'b1;
          proc_next.fault_totals = 1'b1;
        end else if (sample_value > cfg_reg[IDX_QMAX]) begin
          eval_next.over = 1'b1;
          proc_next.fault_totals = 1'b1;
          eval_next.overload = sample_value > tmq;
          if (sample_value > crit) begin
            eval_next.critical = 1'b1;
            value_next = crit;
          end
        end
      end
      default: begin
        eval_next.lim = '0;
      end
    endcase
    eval_next.under = eval_next.under && cfg_reg[IDX_ENABLE][EN_UNDER];
    eval_next.over = eval_next.over && cfg_reg[IDX_ENABLE][EN_OVER];
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      hyst_under_reg <= 1'b0;
      hyst_over_reg <= 1'b0;
      eval_reg <= '0;
      value_reg <= '0;
      proc_reg <= '0;
    end else if (sample_valid) begin
      hyst_under_reg <= hyst_under_next;
      hyst_over_reg <= hyst_over_next;
      eval_reg <= eval_next;
      value_reg <= value_next;
      proc_reg <= proc_next;
    end
  end

  // pulse output backlog check
  assign pulse_cap = {4'h0, cfg_reg[IDX_MAXFREQ]} * {32'h00000000, PULSE_WINDOW_S};

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pulse_ovl_reg <= 1'b0;
    end else begin
      pulse_ovl_reg <= {4'h0, pulse_pending} > pulse_cap;
    end
  end

  // serial update watchdog in millisecond ticks
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      tick_cnt_reg <= '0;
      since_ms_reg <= '0;
      timeout_reg <= 1'b0;
    end else begin
      if (serial_write) begin
        tick_cnt_reg <= '0;
        since_ms_reg <= '0;
      end else if (tick_cnt_reg == 18'(CYCLES_PER_TICK - 1)) begin
        tick_cnt_reg <= '0;
        if (since_ms_reg != 32'hFFFFFFFF) begin
          since_ms_reg <= since_ms_reg + 32'h00000001;
        end
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 18'h00001;
      end
      timeout_reg <= (cfg_reg[IDX_TMO] != 32'h00000000) &&
                     (since_ms_reg >= cfg_reg[IDX_TMO]);
    end
  end

  always_comb begin
    alarms = eval_reg;
    alarms.pulse_out_ovl = pulse_ovl_reg;
    alarms.timeout = timeout_reg;
  end

  assign calc_value = value_reg;
  assign proc = proc_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_reg);

  property p_under_set;
    sample_valid && mode == MODE_LOOP && sample_value < CUR_UNDER_SET_UA &&
      cfg_reg[IDX_ENABLE][EN_UNDER] && !wr_pend_reg |=> alarms.under;
  endproperty
  a_under_set: assert property (p_under_set) else $error("under-range not set");

  property p_under_hold;
    hyst_under_reg && sample_valid && mode == MODE_LOOP && sample_value <= CUR_UNDER_CLR_UA
      |=> hyst_under_reg;
  endproperty
  a_under_hold: assert property (p_under_hold) else $error("under-range cleared early");

  property p_clamp;
    sample_valid && mode == MODE_LOOP && sample_value < CUR_ZERO_UA
      |=> calc_value == $past(cfg_reg[IDX_LRV]);
  endproperty
  a_clamp: assert property (p_clamp) else $error("low current not clamped");

  property p_over_set;
    sample_valid && mode == MODE_LOOP && sample_value > CUR_OVER_SET_UA &&
      cfg_reg[IDX_ENABLE][EN_OVER] && !wr_pend_reg |=> alarms.over;
  endproperty
  a_over_set: assert property (p_over_set) else $error("over-range not set");

  property p_cutoff_zero;
    alarms.cutoff && !proc.totalize_stop |-> calc_value == '0;
  endproperty
  a_cutoff_zero: assert property (p_cutoff_zero) else $error("cut-off value not zero");

  property p_suppress;
    sample_valid && !cfg_reg[IDX_ENABLE][EN_UNDER] && !wr_pend_reg |=> !alarms.under;
  endproperty
  a_suppress: assert property (p_suppress) else $error("disabled alarm shown");

  property p_critical;
    alarms.critical |-> alarms.overload && proc.fault_totals;
  endproperty
  a_critical: assert property (p_critical) else $error("critical without fault totals");

  property p_pulse_cut;
    sample_valid && mode == MODE_PULSE && sample_value < cfg_reg[IDX_QCUT] && !wr_pend_reg
      |=> alarms.cutoff && proc.totalize_stop;
  endproperty
  a_pulse_cut: assert property (p_pulse_cut) else $error("flow cut-off missed");

  property p_pulse_ovl;
    {4'h0, pulse_pending} > pulse_cap && !wr_pend_reg |=> alarms.pulse_out_ovl;
  endproperty
  a_pulse_ovl: assert property (p_pulse_ovl) else $error("pulse output overload missed");

  property p_tmo_clear;
    serial_write && cfg_reg[IDX_TMO] > 32'h00000001 && !wr_pend_reg |-> ##2 !alarms.timeout;
  endproperty
  a_tmo_clear: assert property (p_tmo_clear) else $error("timeout after fresh write");

  c_under: cover property (sample_valid ##1 alarms.under);
  c_critical: cover property (alarms.critical);
  c_discrepancy: cover property (alarms.discrepancy);
  c_timeout: cover property (alarms.timeout);
endmodule

// ==== verif/iocae_field_model.sv ====
// field-side model: transmitters, pulse meter and serial master
`timescale 1ns/1ps
module iocae_field_model
  import iocae_pkg::*;
(
  input wire logic ref_clk,
  output logic sample_valid,
  output iocae_val_t sample_value,
  output iocae_val_t peer_a_value,
  output iocae_val_t peer_b_value,
  output logic [31:0] pulse_pending,
  output logic serial_write
);
  initial begin
    sample_valid = 1'b0;
    sample_value = 32'sh0;
    peer_a_value = 32'sh0;
    peer_b_value = 32'sh0;
    pulse_pending = 32'h0;
    serial_write = 1'b0;
  end

  // one-cycle strobe, value scrambled once the strobe is gone
  task automatic send(input iocae_val_t v, input iocae_val_t pa);
    sample_valid <= 1'b1;
    sample_value <= v;
    peer_a_value <= pa;
    peer_b_value <= pa;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    sample_value <= ~v;
  endtask

  task automatic set_pending(input logic [31:0] n);
    pulse_pending <= n;
  endtask

  // serial master rewrites the channel value
  task automatic rewrite();
    serial_write <= 1'b1;
    @(posedge ref_clk);
    serial_write <= 1'b0;
  endtask
endmodule

// ==== verif/iocae_top_tb.sv ====
// self-checking testbench of the channel alarm evaluator
`timescale 1ns/1ps
module iocae_top_tb
  import iocae_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic sample_valid;
  iocae_val_t sample_value;
  iocae_val_t peer_a_value;
  iocae_val_t peer_b_value;
  logic [31:0] pulse_pending;
  logic serial_write;
  iocae_alarm_s alarms;
  iocae_val_t calc_value;
  iocae_proc_s proc;
  int fails = 0;
  int checks_done = 0;
  iocae_val_t cfg [NUM_CFG];
  logic und_h = 1'b0;
  logic ovr_h = 1'b0;
  logic [31:0] lf = 32'h0AED;
  iocae_val_t lp [6] = '{32'shD48, 32'shED8, 32'sh1004, 32'sh5078, 32'sh4EE8, 32'sh4DBC};
  iocae_val_t sf [3] = '{32'shFFFFFFC4, 32'sh96, 32'sh1770};
  iocae_val_t pp [7] = '{32'sh32, 32'sh12C, 32'sh2BC, 32'sh5DC, 32'sh9C4, 32'shDAC, 32'sh1388};

  assign hready = hreadyout;
  always #2.5 ref_clk = ~ref_clk;

  iocae_top #(.CYCLES_PER_TICK(4)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_valid(sample_valid),
    .sample_value(sample_value), .peer_a_value(peer_a_value), .peer_b_value(peer_b_value),
    .pulse_pending(pulse_pending), .serial_write(serial_write), .alarms(alarms),
    .calc_value(calc_value), .proc(proc)
  );

  iocae_field_model u_field (
    .ref_clk(ref_clk), .sample_valid(sample_valid), .sample_value(sample_value),
    .peer_a_value(peer_a_value), .peer_b_value(peer_b_value),
    .pulse_pending(pulse_pending), .serial_write(serial_write)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_of_test();
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // let n edges pass, then look at the outputs mid-cycle
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // single ahb-lite transfer, waits on hready in both phases
  task automatic bus(input logic w, input logic [4:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= 32'(idx) << ADDR_LSB;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    q = hrdata;
  endtask

  task automatic wr(input logic [4:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
    if (idx < NUM_CFG) cfg[idx] = d;
  endtask

  task automatic rd_chk(input logic [4:0] idx, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, q);
    chk("hrdata", e, q);
    chk("hresp", 32'h0, 32'(hresp));
  endtask

  // strobe one sample and compare outputs against the expected regions
  task automatic sample(input iocae_val_t v, input iocae_val_t pa, input logic cc);
    iocae_alarm_s ea;
    iocae_val_t e;
    iocae_val_t lv;
    iocae_val_t cv;
    iocae_val_t ol;
    logic [2:0] ep;
    logic [2:0] m;
    ea = '0;
    ep = '0;
    m = cfg[IDX_CTRL][2:0];
    u_field.send(v, pa);
    e = (v < CUR_ZERO_UA ? CUR_ZERO_UA : v) - CUR_ZERO_UA;
    e = cfg[IDX_LRV] + iocae_val_t'((longint'(e) * cfg[IDX_GAIN]) >>> GAIN_SHIFT);
    lv = v;
    cv = v;
    if (m <= 3'h1) begin
      if (v < CUR_UNDER_SET_UA) und_h = 1'b1;
      else if (v > CUR_UNDER_CLR_UA) und_h = 1'b0;
      if (v > CUR_OVER_SET_UA) ovr_h = 1'b1;
      else if (v < CUR_OVER_CLR_UA) ovr_h = 1'b0;
      lv = e;
      cv = e;
      ea.under = und_h || (m == 3'h1 && v < CUR_ZERO_UA);
      ea.over = ovr_h || (m == 3'h1 && e > cfg[IDX_OVLD]);
    end
    if (m == 3'h1) begin
      ea.cutoff = !ea.under && e < cfg[IDX_CUTOFF];
      ea.discrepancy = cfg[IDX_CTRL][4:3] != 2'h0 &&
                       (e - pa > cfg[IDX_DEV] || pa - e > cfg[IDX_DEV]);
      ep = {ea.under, 1'b0, e > cfg[IDX_OVLD]};
      if (ea.cutoff) cv = 32'sh0;
      if (ep[0]) cv = cfg[IDX_OVLD];
    end
    if (m == 3'h2 || m == 3'h3) begin
      ea.under = v < cfg[m == 3'h2 ? IDX_LSCALE : IDX_LFREQ];
      ea.over = v > cfg[m == 3'h2 ? IDX_HSCALE : IDX_HFREQ];
    end
    if (m == 3'h4) begin
      ol = iocae_val_t'((longint'(cfg[IDX_QMAX]) * cfg[IDX_OVF]) >>> OVF_FRAC);
      ea.cutoff = v < cfg[IDX_QCUT];
      ea.under = !ea.cutoff && v < cfg[IDX_QMIN];
      ea.over = v > cfg[IDX_QMAX];
      ea.overload = ea.over && v > ol;
      ol = ol + (ol >>> CRIT_HALF_SHIFT);
      ea.critical = ea.over && v > ol;
      if (ea.critical) cv = ol;
      ep = {1'b0, ea.cutoff, ea.under || ea.over};
    end
    ea.under = ea.under && cfg[IDX_ENABLE][EN_UNDER];
    ea.over = ea.over && cfg[IDX_ENABLE][EN_OVER];
    ea.lim = {lv < cfg[IDX_LOW_LOW_THRESHOLD], lv < cfg[IDX_LO], lv > cfg[IDX_HI], lv > cfg[IDX_HIGH_HIGH_THRESHOLD]} &
             {cfg[IDX_ENABLE][2], cfg[IDX_ENABLE][3], cfg[IDX_ENABLE][4], cfg[IDX_ENABLE][5]};
    if (m > 3'h4) ea.lim = '0;
    @(negedge ref_clk);
    chk("alarms", 32'(ea[9:0]), 32'(alarms[9:0]));
    if (cc) chk("calc_value", cv, calc_value);
    if (m == 3'h1 || m >= 3'h4) chk("proc", 32'(ep), 32'(proc));
    @(posedge ref_clk);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end

  initial begin
    foreach (cfg[i]) cfg[i] = 32'sh0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle(6);
    chk("alarms", 32'h0, 32'(alarms));
    @(posedge ref_clk);
    for (int i = 0; i < NUM_CFG; i++) rd_chk(5'(i), 32'h0);
    wr(5'h18, 32'hFFFFFFFF);
    rd_chk(5'h18, 32'h0);
    wr(IDX_GAIN, 32'h10000);
    wr(IDX_LOW_LOW_THRESHOLD, 32'h64);
    wr(IDX_LO, 32'hC8);
    wr(IDX_HI, 32'h3A98);
    wr(IDX_HIGH_HIGH_THRESHOLD, 32'h3E80);
    rd_chk(IDX_HI, 32'h3A98);
    sample(32'shD48, 32'sh0, 1'b1);
    wr(IDX_ENABLE, 32'h3F);
    foreach (lp[i]) sample(lp[i], 32'sh0, 1'b1);
    repeat (24) begin
      lf = lfsr(lf);
      sample(iocae_val_t'(lf % 32'h55F0), 32'sh0, 1'b1);
    end
    wr(IDX_CTRL, 32'h9);
    wr(IDX_CUTOFF, 32'h1F4);
    wr(IDX_OVLD, 32'h4074);
    wr(IDX_DEV, 32'h64);
    sample(32'sh1F40, 32'shFA0, 1'b1);
    sample(32'sh1F40, 32'sh1005, 1'b1);
    sample(32'sh1F40, 32'sh1004, 1'b1);
    sample(32'sh1068, 32'shC8, 1'b1);
    sample(32'shBB8, 32'sh0, 1'b0);
    sample(32'shE74, 32'sh0, 1'b0);
    sample(32'sh5078, 32'sh40D8, 1'b1);
    sample(32'sh1F40, 32'shFA0, 1'b1);
    wr(IDX_LSCALE, 32'hFFFFFFCE);
    wr(IDX_HSCALE, 32'h12C);
    wr(IDX_LFREQ, 32'hA);
    wr(IDX_HFREQ, 32'h1388);
    for (int m = 2; m < 4; m++) begin
      wr(IDX_CTRL, 32'(m));
      foreach (sf[i]) sample(sf[i], 32'sh0, 1'b0);
    end
    wr(IDX_CTRL, 32'h4);
    wr(IDX_QCUT, 32'h64);
    wr(IDX_QMIN, 32'h1F4);
    wr(IDX_QMAX, 32'h3E8);
    wr(IDX_OVF, 32'h200);
    wr(IDX_HI, 32'h4B0);
    wr(IDX_HIGH_HIGH_THRESHOLD, 32'hA28);
    foreach (pp[i]) sample(pp[i], 32'sh0, 1'b1);
    sample(32'sh64, 32'sh0, 1'b1);
    wr(IDX_CTRL, 32'h5);
    sample(32'sh1388, 32'sh0, 1'b1);
    rd_chk(IDX_VALUE, 32'h1388);
    wr(IDX_MAXFREQ, 32'h64);
    u_field.set_pending(32'h3E9);
    settle(3);
    chk("pulse_out_ovl", 32'h1, 32'(alarms.pulse_out_ovl));
    @(posedge ref_clk);
    rd_chk(IDX_STATUS, 32'h400);
    u_field.set_pending(32'h3E8);
    settle(3);
    chk("pulse_out_ovl", 32'h0, 32'(alarms.pulse_out_ovl));
    @(posedge ref_clk);
    wr(IDX_TMO, 32'h5);
    u_field.rewrite();
    settle(8);
    chk("timeout", 32'h0, 32'(alarms.timeout));
    settle(20);
    chk("timeout", 32'h1, 32'(alarms.timeout));
    @(posedge ref_clk);
    u_field.rewrite();
    settle(3);
    chk("timeout", 32'h0, 32'(alarms.timeout));
    end_of_test();
  end
endmodule
